// *** pkg/tbc_defines.svh ***
/*
  constants for the two-wire bus controller: timing counts, error codes,
  command codes and reset values.
  assumes a single 200 MHz processor clock feeds the controller.
*/
// Notes on behaviour
// RULE1: reading master data returns last byte received, zero-extended.
// RULE2: writing master data sets the next byte to transmit.
// RULE3: master disabled stops all activity and never drives the bus.
// RULE4: master enabled accepts commands and runs bus transactions.
// RULE5: each operation reports none, address nack, data nack or arbitration lost.
// RULE6: fast select gives 400 kbps, otherwise 100 kbps.
// RULE7: init programs speed and leaves the master enabled.
// RULE8: bus clock is derived from the processor clock.
// RULE9: clearing the master interrupt deasserts it; handler clears early.
// RULE10: disabled interrupt is masked from the line; raw keeps updating.
// RULE11: enabled interrupt forwards the active source to the line.
// RULE12: raw and masked status both available; masked is raw and enable.
// RULE13: programmable 7-bit target address sent at transaction start.
// RULE14: direction flag set means read, clear means write.
// RULE15: reading slave data returns the last byte received by the slave.
// RULE16: interrupt rises when the master finishes and is no longer busy.
// RULE17: divider rounds so the bus clock never exceeds the selected rate.
`ifndef TBC_DEFINES_SVH
`define TBC_DEFINES_SVH

`define TBC_CLK_HZ 200000000
`define TBC_STD_BPS 100000
`define TBC_FAST_BPS 400000
// quarter-period counts, rounded up so the rate never exceeds the target
`define TBC_STD_QTR ((`TBC_CLK_HZ + 4 * `TBC_STD_BPS - 1) / (4 * `TBC_STD_BPS))
`define TBC_FAST_QTR ((`TBC_CLK_HZ + 4 * `TBC_FAST_BPS - 1) / (4 * `TBC_FAST_BPS))

`define TBC_ERR_NONE 2'h0
`define TBC_ERR_ADDR_ACK 2'h1
`define TBC_ERR_DATA_ACK 2'h2
`define TBC_ERR_ARB_LOST 2'h3

// command bits: {stop, start, run}, ack bit for receive
`define TBC_CMD_RUN 0
`define TBC_CMD_START 1
`define TBC_CMD_STOP 2
`define TBC_CMD_ACK 3

`define TBC_BYTE_RST 8'h00
`define TBC_ADDR_RST 7'h00

`endif

// *** pkg/tbc_pkg.sv ***
/*
  types shared by the two-wire bus controller.
  assumes tbc_defines.svh is included by the design files.
*/
package tbc_pkg;
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_START = 8'h02,
    ST_ADDR  = 8'h04,
    ST_AACK  = 8'h08,
    ST_DATA  = 8'h10,
    ST_DACK  = 8'h20,
    ST_STOP  = 8'h40,
    ST_HOLD  = 8'h80
  } tbc_state_t;
endpackage : tbc_pkg

// *** core/tbc_tick.sv ***
/*
  quarter-bit tick divider for the two-wire bus.
  assumes the processor clock; one-cycle tick pulse out.
*/
`include "tbc_defines.svh"
module tbc_tick (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic run_i,
  input wire logic fast_i,
  // tick
  output logic tick_o
);
  localparam logic [9:0] STD_Q = 10'(`TBC_STD_QTR);
  localparam logic [9:0] FAST_Q = 10'(`TBC_FAST_QTR);
  logic [9:0] cnt_q;
  logic [9:0] lim;

  assign lim = fast_i ? FAST_Q : STD_Q; // RULE6 RULE17

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || !run_i) begin
      cnt_q <= 10'h000;
      tick_o <= 1'b0;
    end else if (cnt_q >= lim - 10'h001) begin
      cnt_q <= 10'h000;
      tick_o <= 1'b1; // RULE8
    end else begin
      cnt_q <= cnt_q + 10'h001;
      tick_o <= 1'b0;
    end
  end

  a_tick_single: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    tick_o |=> !tick_o) else $error("tick lasted two cycles"); // RULE17
endmodule : tbc_tick

// *** core/tbc_core.sv ***
/*
  two-wire bus master with slave receive register.
  assumes open-drain pins resolved outside, inputs synchronous to the clock.
*/
`include "tbc_defines.svh"
module tbc_core (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // master control
  input wire logic init_i,
  input wire logic enable_set_i,
  input wire logic enable_clr_i,
  input wire logic fast_rate_select_i,
  input wire logic [6:0] target_bus_address_i,
  input wire logic read_direction_flag_i,
  input wire logic addr_wr_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_wr_i,
  input wire logic [3:0] cmd_i,
  input wire logic cmd_wr_i,
  // interrupt control
  input wire logic int_clr_i,
  input wire logic int_en_set_i,
  input wire logic int_en_clr_i,
  input wire logic masked_status_select_i,
  // master status
  output logic [7:0] master_rx_data_o,
  output logic [1:0] error_status_o,
  output logic arbitration_lost_error_o,
  output logic busy_o,
  output logic bus_busy_o,
  output logic enabled_o,
  output logic int_status_o,
  output logic irq_o,
  // slave receive
  input wire logic [6:0] own_address_i,
  output logic [7:0] slave_rx_data_o,
  // bus pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);
  tbc_pkg::tbc_state_t st_q;
  logic en_q, fast_q, dir_q, int_raw_q, int_en_q, ack_q, stop_q;
  logic [6:0] addr_q;
  logic [7:0] tx_q, sh_q;
  logic [2:0] bit_q;
  logic [1:0] ph_q;
  logic tick, done;
  logic scl_d_q, sda_d_q, s_act_q, s_hit_q;
  logic [3:0] s_cnt_q;
  logic [7:0] s_sh_q;

  tbc_tick u_tick (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(en_q && st_q != tbc_pkg::ST_IDLE),
    .fast_i(fast_q),
    .tick_o(tick)
  );

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      en_q <= 1'b0;
      fast_q <= 1'b0;
    end else if (init_i) begin
      fast_q <= fast_rate_select_i; // RULE7
      en_q <= 1'b1; // RULE7
    end else if (enable_clr_i) begin
      en_q <= 1'b0; // RULE3
    end else if (enable_set_i) begin
      en_q <= 1'b1; // RULE4
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      addr_q <= `TBC_ADDR_RST;
      dir_q <= 1'b0;
      tx_q <= `TBC_BYTE_RST;
    end else begin
      if (addr_wr_i) begin
        addr_q <= target_bus_address_i; // RULE13
        dir_q <= read_direction_flag_i; // RULE14
      end
      if (tx_wr_i) begin
        tx_q <= tx_data_i; // RULE2
      end
    end
  end

  // a phase is one quarter bit: 0 low, 1 data set, 2 high, 3 sample
  assign done = tick && ph_q == 2'h3;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || !en_q) begin
      st_q <= tbc_pkg::ST_IDLE; // RULE3
      ph_q <= 2'h0;
      bit_q <= 3'h7;
      sh_q <= 8'h00;
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
      busy_o <= 1'b0;
      error_status_o <= `TBC_ERR_NONE;
      master_rx_data_o <= `TBC_BYTE_RST;
      ack_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      if (tick) begin
        ph_q <= ph_q + 2'h1;
      end
      case (st_q)
        tbc_pkg::ST_IDLE, tbc_pkg::ST_HOLD: begin
          ph_q <= 2'h0;
          if (cmd_wr_i && cmd_i[`TBC_CMD_RUN]) begin // RULE4
            busy_o <= 1'b1;
            ack_q <= cmd_i[`TBC_CMD_ACK];
            stop_q <= cmd_i[`TBC_CMD_STOP];
            error_status_o <= `TBC_ERR_NONE;
            bit_q <= 3'h7;
            if (cmd_i[`TBC_CMD_START]) begin
              st_q <= tbc_pkg::ST_START;
              sh_q <= {addr_q, dir_q}; // RULE13 RULE14
            end else begin
              st_q <= tbc_pkg::ST_DATA;
              sh_q <= dir_q ? 8'hFF : tx_q;
            end
          end else if (cmd_wr_i && cmd_i[`TBC_CMD_STOP]) begin
            st_q <= tbc_pkg::ST_STOP;
            busy_o <= 1'b1;
          end
        end
        tbc_pkg::ST_START: begin
          if (st_q == tbc_pkg::ST_START && bus_busy_o && !sda_oe_o) begin
            error_status_o <= `TBC_ERR_ARB_LOST; // RULE5
            busy_o <= 1'b0;
            st_q <= tbc_pkg::ST_IDLE;
          end else begin
            sda_oe_o <= 1'b1;
            if (done) begin
              scl_oe_o <= 1'b1;
              st_q <= tbc_pkg::ST_ADDR;
            end
          end
        end
        tbc_pkg::ST_ADDR, tbc_pkg::ST_DATA: begin
          if (tick && ph_q == 2'h0) begin
            scl_oe_o <= 1'b1;
            sda_oe_o <= !sh_q[7];
          end
          if (tick && ph_q == 2'h1) begin
            scl_oe_o <= 1'b0;
          end
          // a receiving master leaves data released, so only sent bits contend
          if (tick && ph_q == 2'h2 && (st_q == tbc_pkg::ST_ADDR || !dir_q)
              && sda_oe_o != !sda_i) begin
            error_status_o <= `TBC_ERR_ARB_LOST; // RULE5
            sda_oe_o <= 1'b0;
            busy_o <= 1'b0;
            st_q <= tbc_pkg::ST_IDLE;
          end
          if (done) begin
            scl_oe_o <= 1'b1;
            sh_q <= {sh_q[6:0], sda_i};
            bit_q <= bit_q - 3'h1;
            if (bit_q == 3'h0) begin
              st_q <= st_q == tbc_pkg::ST_ADDR ? tbc_pkg::ST_AACK
                                              : tbc_pkg::ST_DACK;
            end
          end
        end
        default: begin
          // ack bit or stop condition
          if (tick && ph_q == 2'h0) begin
            scl_oe_o <= 1'b1;
            if (st_q == tbc_pkg::ST_STOP) begin
              sda_oe_o <= 1'b1;
            end else begin
              sda_oe_o <= st_q == tbc_pkg::ST_DACK && dir_q && ack_q;
            end
          end
          if (tick && ph_q == 2'h1) begin
            scl_oe_o <= 1'b0;
          end
          if (tick && ph_q == 2'h2 && st_q == tbc_pkg::ST_STOP) begin
            sda_oe_o <= 1'b0;
          end
          if (done) begin
            bit_q <= 3'h7;
            if (st_q == tbc_pkg::ST_STOP) begin
              busy_o <= 1'b0; // RULE16
              st_q <= tbc_pkg::ST_IDLE;
            end else if (st_q == tbc_pkg::ST_AACK && sda_i) begin
              error_status_o <= `TBC_ERR_ADDR_ACK; // RULE5
              st_q <= tbc_pkg::ST_STOP;
              scl_oe_o <= 1'b1;
            end else if (st_q == tbc_pkg::ST_AACK) begin
              st_q <= tbc_pkg::ST_DATA;
              sh_q <= dir_q ? 8'hFF : tx_q;
              scl_oe_o <= 1'b1;
            end else begin
              scl_oe_o <= 1'b1;
              if (dir_q) begin
                master_rx_data_o <= sh_q; // RULE1
              end else if (sda_i) begin
                error_status_o <= `TBC_ERR_DATA_ACK; // RULE5
              end
              if (stop_q || (!dir_q && sda_i)) begin
                st_q <= tbc_pkg::ST_STOP;
              end else begin
                st_q <= tbc_pkg::ST_HOLD;
                busy_o <= 1'b0; // RULE16
              end
            end
          end
        end
      endcase
    end
  end

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      arbitration_lost_error_o <= 1'b0;
      enabled_o <= 1'b0;
    end else begin
      arbitration_lost_error_o <= error_status_o == `TBC_ERR_ARB_LOST;
      enabled_o <= en_q;
    end
  end

  // interrupt: set on busy fall wins over a clear in the same cycle
  logic busy_d_q;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      busy_d_q <= 1'b0;
      int_raw_q <= 1'b0;
      int_en_q <= 1'b0;
      int_status_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      busy_d_q <= busy_o;
      if (busy_d_q && !busy_o) begin
        int_raw_q <= 1'b1; // RULE16 RULE10
      end else if (int_clr_i) begin
        int_raw_q <= 1'b0; // RULE9
      end
      if (int_en_set_i) begin
        int_en_q <= 1'b1; // RULE11
      end else if (int_en_clr_i) begin
        int_en_q <= 1'b0; // RULE10
      end
      irq_o <= int_raw_q && int_en_q; // RULE10 RULE11
      int_status_o <= masked_status_select_i ? int_raw_q && int_en_q
                                             : int_raw_q; // RULE12
    end
  end

  // bus watcher and slave receiver
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
      bus_busy_o <= 1'b0;
      s_act_q <= 1'b0;
      s_hit_q <= 1'b0;
      s_cnt_q <= 4'h0;
      s_sh_q <= 8'h00;
      slave_rx_data_o <= `TBC_BYTE_RST;
    end else begin
      scl_d_q <= scl_i;
      sda_d_q <= sda_i;
      if (scl_i && sda_d_q && !sda_i) begin
        bus_busy_o <= 1'b1;
        s_act_q <= 1'b1;
        s_hit_q <= 1'b0;
        s_cnt_q <= 4'h0;
      end else if (scl_i && !sda_d_q && sda_i) begin
        bus_busy_o <= 1'b0;
        s_act_q <= 1'b0;
      end else if (s_act_q && !scl_d_q && scl_i) begin
        if (s_cnt_q == 4'h8) begin
          s_cnt_q <= 4'h0;
          if (s_sh_q[7:1] == own_address_i && !s_sh_q[0] && !s_hit_q) begin
            s_hit_q <= 1'b1;
          end else if (s_hit_q) begin
            slave_rx_data_o <= s_sh_q; // RULE15
          end
        end else begin
          s_sh_q <= {s_sh_q[6:0], sda_i};
          s_cnt_q <= s_cnt_q + 4'h1;
        end
      end
    end
  end

  a_off_quiet: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !en_q |=> !scl_oe_o && !sda_oe_o && !busy_o) // RULE3
    else $error("disabled master drove the bus");
  a_init_enables: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    init_i |=> en_q && fast_q == $past(fast_rate_select_i)) // RULE7
    else $error("init did not enable or set speed");
  a_int_on_done: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $fell(busy_o) |=> int_raw_q) // RULE16
    else $error("no interrupt after done");
  a_int_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    int_clr_i && !(busy_d_q && !busy_o) |=> !int_raw_q) // RULE9
    else $error("clear did not drop interrupt");
  a_irq_masked: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !int_en_q |=> !irq_o) // RULE10
    else $error("masked interrupt reached line");
  a_irq_forward: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    int_raw_q && int_en_q |=> irq_o) // RULE11
    else $error("enabled interrupt not forwarded");
  a_status_sel: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    masked_status_select_i && !int_en_q |=> !int_status_o) // RULE12
    else $error("masked status ignores enable");
  a_addr_store: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    addr_wr_i |=> addr_q == $past(target_bus_address_i)
      && dir_q == $past(read_direction_flag_i)) // RULE13
    else $error("address or direction not stored");
  a_tx_store: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    tx_wr_i |=> tx_q == $past(tx_data_i)) // RULE2
    else $error("tx byte not stored");
  a_arb_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    error_status_o == `TBC_ERR_ARB_LOST && en_q
      |=> arbitration_lost_error_o) // RULE5
    else $error("arbitration flag missing");
endmodule : tbc_core

// *** tb/tbc_peer.sv ***
/*
  far-side bus device model: an addressed slave that acks, returns a
  read byte, may refuse data or contest arbitration, and can also act
  as a master writing one byte.
  assumes pull-ups on both lines, resolved by the bench.
*/
module tbc_peer #(
  parameter logic [6:0] PEER_ADDR = 7'h52
) (
  // bus lines
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe_o,
  output logic sda_oe_o,
  // behaviour selection
  input wire logic nack_data_i,
  input wire logic arb_i,
  input wire logic [7:0] rd_byte_i,
  // what was seen on the bus
  output logic [7:0] got_addr_o,
  output logic [7:0] got_data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic drv = 1'b0;

  task automatic get_byte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge scl_i);
      b[i] = sda_i;
    end
  endtask : get_byte

  // acts only on starts made by others; own starts are skipped
  initial begin
    {scl_oe_o, sda_oe_o} = 2'b00;
    {got_addr_o, got_data_o} = 16'h0000;
    forever begin
      @(negedge sda_i iff (scl_i === 1'b1 && !drv));
      if (arb_i) begin
        // holds data low over a released bit, then lets go
        @(negedge scl_i);
        sda_oe_o = 1'b1;
        #4000;
        sda_oe_o = 1'b0;
      end else begin
        get_byte(got_addr_o);
        if (got_addr_o[7:1] == PEER_ADDR) begin
          @(negedge scl_i);
          sda_oe_o = 1'b1;
          @(negedge scl_i);
          sda_oe_o = 1'b0;
          if (got_addr_o[0]) begin
            for (int i = 7; i >= 0; i--) begin
              sda_oe_o = ~rd_byte_i[i];
              @(negedge scl_i);
            end
            sda_oe_o = 1'b0;
          end else begin
            get_byte(got_data_o);
            @(negedge scl_i);
            sda_oe_o = !nack_data_i;
            @(negedge scl_i);
            sda_oe_o = 1'b0;
          end
        end
      end
    end
  end

  // data moves 100 ns after the clock falls, never at the same instant
  task automatic send(input logic [6:0] a, input logic [7:0] d);
    logic [17:0] bits;
    bits = {a, 1'b0, 1'b1, d, 1'b1};
    drv = 1'b1;
    sda_oe_o = 1'b1;
    #500;
    for (int i = 17; i >= 0; i--) begin
      scl_oe_o = 1'b1;
      #100;
      sda_oe_o = ~bits[i];
      #400;
      scl_oe_o = 1'b0;
      #500;
    end
    scl_oe_o = 1'b1;
    #100;
    sda_oe_o = 1'b1;
    #400;
    scl_oe_o = 1'b0;
    #500;
    sda_oe_o = 1'b0;
    drv = 1'b0;
  endtask : send
endmodule : tbc_peer

// *** tb/tbc_core_bench.sv ***
/*
  self-checking bench for the bus controller, one task per scenario.
  assumes the peer model on the far side and pull-ups on both lines.
*/
`include "tbc_defines.svh"
module tbc_core_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic init_i, enable_set_i, enable_clr_i, addr_wr_i, tx_wr_i, cmd_wr_i;
  logic int_clr_i, int_en_set_i, int_en_clr_i, masked_status_select_i;
  logic fast_rate_select_i, read_direction_flag_i, nack_data, arb;
  logic [6:0] target_bus_address_i;
  logic [7:0] tx_data_i, master_rx_data_o, slave_rx_data_o;
  logic [7:0] got_addr, got_data;
  logic [3:0] cmd_i;
  logic [1:0] error_status_o;
  logic arbitration_lost_error_o, busy_o, bus_busy_o, enabled_o;
  logic int_status_o, irq_o, scl_o, scl_oe_o, sda_o, sda_oe_o;
  logic p_scl_oe, p_sda_oe;
  wire scl = (scl_oe_o ? scl_o : 1'b1) & ~p_scl_oe;
  wire sda = (sda_oe_o ? sda_o : 1'b1) & ~p_sda_oe;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int nrise = 0;
  time t1 = 0;
  time per = 0;

  tbc_core u_dut (
    .ref_clk_i, .rst_n_i, .init_i, .enable_set_i, .enable_clr_i,
    .fast_rate_select_i, .target_bus_address_i, .read_direction_flag_i,
    .addr_wr_i, .tx_data_i, .tx_wr_i, .cmd_i, .cmd_wr_i, .int_clr_i,
    .int_en_set_i, .int_en_clr_i, .masked_status_select_i,
    .master_rx_data_o, .error_status_o, .arbitration_lost_error_o,
    .busy_o, .bus_busy_o, .enabled_o, .int_status_o, .irq_o,
    .own_address_i(7'h2A), .slave_rx_data_o, .scl_i(scl), .scl_o,
    .scl_oe_o, .sda_i(sda), .sda_o, .sda_oe_o
  );

  tbc_peer u_peer (
    .scl_i(scl), .sda_i(sda), .scl_oe_o(p_scl_oe), .sda_oe_o(p_sda_oe),
    .nack_data_i(nack_data), .arb_i(arb), .rd_byte_i(8'h3C),
    .got_addr_o(got_addr), .got_data_o(got_data)
  );

  always #2.5 ref_clk_i = ~ref_clk_i;

  // period between the 2nd and 3rd clock rise lies inside the address
  always @(posedge scl) begin
    nrise++;
    if (nrise == 3) per = $time - t1;
    t1 = $time;
  end

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict;
    if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic quiet;
    {init_i, enable_set_i, enable_clr_i, addr_wr_i, tx_wr_i} = 5'h00;
    {cmd_wr_i, int_clr_i, int_en_set_i, int_en_clr_i} = 4'h0;
  endtask : quiet

  // strobes set at a falling edge live for exactly one rising edge
  task automatic step(input int n = 1);
    repeat (n) begin
      @(negedge ref_clk_i);
      quiet();
    end
  endtask : step

  task automatic run(input logic [6:0] a, input logic d, input logic [7:0] t,
                     input logic [3:0] c = 4'h7);
    int n = 0;
    target_bus_address_i = a;
    read_direction_flag_i = d;
    tx_data_i = t;
    {addr_wr_i, tx_wr_i, int_clr_i} = 3'b111;
    step();
    cmd_i = c;
    cmd_wr_i = 1'b1;
    nrise = 0;
    step(2);
    chk(busy_o, 1);
    while (busy_o !== 1'b0 && n < 30000) begin
      step();
      n++;
    end
    chk(busy_o, 0);
    step(3);
  endtask : run

  task automatic refused;
    cmd_i = 4'h7;
    cmd_wr_i = 1'b1;
    step(20);
    chk(busy_o, 0);
    chk(sda_oe_o | scl_oe_o, 0);
  endtask : refused

  task automatic s_send;
    {fast_rate_select_i, init_i, int_en_set_i} = 3'b111;
    step(2);
    chk(enabled_o, 1);
    run(7'h52, 1'b0, 8'hA5);
    chk(error_status_o, `TBC_ERR_NONE);
    chk(got_addr, 8'hA4);
    chk(got_data, 8'hA5);
    chk(per, 2500);
    chk(irq_o, 1);
    masked_status_select_i = 1'b1;
    step(2);
    chk(int_status_o, 1);
    int_clr_i = 1'b1;
    step(3);
    chk({irq_o, int_status_o}, 0);
  endtask : s_send

  task automatic s_read;
    run(7'h52, 1'b1, 8'h00);
    chk(got_addr, 8'hA5);
    chk(master_rx_data_o, 8'h3C);
    chk(error_status_o, `TBC_ERR_NONE);
    // acked read without stop parks the bus, then a bare read goes on
    run(7'h52, 1'b1, 8'h00, 4'hB);
    chk(master_rx_data_o, 8'h3C);
    chk(error_status_o, `TBC_ERR_NONE);
    run(7'h52, 1'b1, 8'h00, 4'h5);
    chk(master_rx_data_o, 8'hFF);
    chk(error_status_o, `TBC_ERR_NONE);
  endtask : s_read

  task automatic s_faults;
    nack_data = 1'b1;
    run(7'h52, 1'b0, 8'h0F);
    chk(error_status_o, `TBC_ERR_DATA_ACK);
    chk(got_data, 8'h0F);
    nack_data = 1'b0;
    arb = 1'b1;
    run(7'h7F, 1'b0, 8'h0F);
    chk(error_status_o, `TBC_ERR_ARB_LOST);
    chk(arbitration_lost_error_o, 1);
    chk(bus_busy_o, 1);
    arb = 1'b0;
    step(1000);
    chk(bus_busy_o, 0);
  endtask : s_faults

  task automatic s_masked;
    {int_en_clr_i, init_i} = 2'b11;
    {fast_rate_select_i, masked_status_select_i} = 2'b00;
    step(2);
    run(7'h11, 1'b0, 8'h0F);
    chk(error_status_o, `TBC_ERR_ADDR_ACK);
    chk(per, 10000);
    chk(irq_o, 0);
    chk(int_status_o, 1);
    masked_status_select_i = 1'b1;
    step(2);
    chk(int_status_o, 0);
  endtask : s_masked

  task automatic s_off_slave;
    enable_clr_i = 1'b1;
    step(2);
    chk(enabled_o, 0);
    refused();
    u_peer.send(7'h2A, 8'hC3);
    step(4);
    chk(slave_rx_data_o, 8'hC3);
  endtask : s_off_slave

  initial begin
    quiet();
    cmd_i = 4'h0;
    tx_data_i = 8'h00;
    target_bus_address_i = 7'h00;
    {fast_rate_select_i, read_direction_flag_i} = 2'b00;
    {masked_status_select_i, nack_data, arb} = 3'b000;
    step(8);
    rst_n_i = 1'b1;
    step(2);
    chk({enabled_o, busy_o, irq_o, error_status_o}, 0);
    refused();
    s_send();
    s_read();
    s_faults();
    s_masked();
    s_off_slave();
    give_verdict();
  end
endmodule : tbc_core_bench
